// File: shared/ptc_pkg.sv
// package for the timer/counter unit: widths, limits, prescaler default
// assumes a single 100 MHz clock domain
package ptc_pkg;
  localparam int          VAL_W       = 16;
  localparam logic [15:0] VAL_MAX     = 16'h7FFF;   // saturation value
  localparam logic [15:0] VAL_ZERO    = 16'h0000;
  localparam logic [15:0] VAL_ONE     = 16'h0001;
  localparam int          CLK_HZ      = 100000000;
  localparam int          TICK_US     = 1;          // default tick period
  localparam int          TICK_CYC    = (CLK_HZ / 1000000) * TICK_US;
  localparam int          PRE_W       = 32;
  typedef enum logic [2:0] {
    PTC_ON_DELAY, PTC_RETENTIVE, PTC_OFF_DELAY, PTC_MONOSTABLE, PTC_UP_COUNT
  } ptc_kind_type;
endpackage

// File: rtl/ptc_prescaler.sv
// tick prescaler: one-cycle pulse every tick_div clocks
// assumes tick_div is held stable and is at least one
`timescale 1ns/100ps
`default_nettype none
module ptc_prescaler #(
  parameter int PRE_W = 32
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             sync_clr,
  // divider
  input  wire logic [PRE_W-1:0] tick_div,
  output logic                  tick
);
  logic [PRE_W-1:0] count;

  // free running divider, cleared with the unit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (sync_clr) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count + 1'b1 >= tick_div) begin
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick  <= 1'b0;
    end
  end
endmodule // ptc_prescaler
`default_nettype wire

// File: rtl/ptc_timer_counter.sv
// timer/counter unit: N elements, each of a fixed kind, sharing one tick
// assumes enable and preset are synchronous to mclk; sync_clr is synchronous
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - on-delay kinds count ticks, saturate 32767
// - on-delay kinds: coil when value >= preset
// - on-delay disabled: clear value and coil
// - on-delay first run clears coil and value
// - retentive disabled: hold value and coil
// - off-delay starts timing on enable fall
// - off-delay ends at preset, coil low
// - off-delay never starts without a fall
// - off-delay enabled: clear value, coil high
// - monostable rise starts timing, coil high
// - monostable ignores enable while timing
// - monostable at preset: stop, clear, coil low
// - up counter counts enable rising edges
// - up counter saturates at 32767
// - up counter coil when count >= preset
module ptc_timer_counter
  import ptc_pkg::*;
#(
  parameter int                         N_ELEM   = 5,
  parameter ptc_kind_type [N_ELEM-1:0]  KINDS    = '{PTC_UP_COUNT, PTC_MONOSTABLE, PTC_OFF_DELAY,
                                                     PTC_RETENTIVE, PTC_ON_DELAY},
  parameter logic [ptc_pkg::PRE_W-1:0]  TICK_DIV = ptc_pkg::PRE_W'(ptc_pkg::TICK_CYC)
) (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  input  wire logic                     sync_clr,
  // scan side
  input  wire logic [N_ELEM-1:0]        enable,
  input  wire logic [ptc_pkg::VAL_W-1:0] preset [N_ELEM],
  // element state
  output logic [ptc_pkg::VAL_W-1:0]     value [N_ELEM],
  output logic [N_ELEM-1:0]             coil,
  output logic                          tick
);
  import ptc_pkg::*;

  logic rst_meta;
  logic rst_n;

  // reset released through two flops, asserted at once
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ptc_prescaler #(.PRE_W(PRE_W)) u_pre (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .sync_clr (sync_clr),
    .tick_div (TICK_DIV),
    .tick     (tick)
  );

  logic [N_ELEM-1:0] en_prev;
  logic [N_ELEM-1:0] active;
  logic [N_ELEM-1:0] first_done;

  genvar g;
  generate
    for (g = 0; g < N_ELEM; g++) begin : g_elem
      wire logic rise = enable[g] & ~en_prev[g];
      wire logic fall = ~enable[g] & en_prev[g];
      wire logic sat  = (value[g] >= VAL_MAX);
      wire logic geq  = (value[g] >= preset[g]);

      // edge history and first-run flag, cleared by either reset
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          en_prev[g]    <= 1'b0;
          first_done[g] <= 1'b0;
        end else if (sync_clr) begin
          en_prev[g]    <= 1'b0;
          first_done[g] <= 1'b0;
        end else begin
          en_prev[g]    <= enable[g];
          first_done[g] <= 1'b1;
        end
      end

      // per-kind value, coil and timing state
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          value[g]  <= VAL_ZERO;
          coil[g]   <= 1'b0;
          active[g] <= 1'b0;
        end else if (sync_clr) begin
          value[g]  <= VAL_ZERO;
          coil[g]   <= 1'b0;
          active[g] <= 1'b0;
        end else begin
          unique case (KINDS[g])
            PTC_ON_DELAY: begin
              if (!first_done[g] || !enable[g]) begin
                value[g] <= VAL_ZERO;
                coil[g]  <= 1'b0;
              end else begin
                if (tick && !sat) value[g] <= value[g] + VAL_ONE;
                coil[g] <= geq;
              end
            end
            PTC_RETENTIVE: begin
              // value and coil simply held while disabled
              if (enable[g]) begin
                if (tick && !sat) value[g] <= value[g] + VAL_ONE;
                coil[g] <= geq;
              end
            end
            PTC_OFF_DELAY: begin
              if (enable[g]) begin
                value[g]  <= VAL_ZERO;
                coil[g]   <= 1'b1;
                active[g] <= 1'b0;
              end else if (fall) begin
                active[g] <= 1'b1;
              end else if (active[g]) begin
                // compare before stepping so value never passes preset
                if (geq) begin
                  active[g] <= 1'b0;
                  coil[g]   <= 1'b0;
                  value[g]  <= preset[g];
                end else if (tick) begin
                  value[g] <= value[g] + VAL_ONE;
                end
              end  // idle low enable: nothing starts
            end
            PTC_MONOSTABLE: begin
              if (!active[g]) begin
                if (rise) begin
                  active[g] <= 1'b1;
                  coil[g]   <= 1'b1;
                end
              end else if (geq) begin
                active[g] <= 1'b0;
                coil[g]   <= 1'b0;
                value[g]  <= VAL_ZERO;
              end else begin  // enable ignored here
                coil[g] <= 1'b1;
                if (tick) value[g] <= value[g] + VAL_ONE;
              end
            end
            PTC_UP_COUNT: begin
              if (rise && !sat) value[g] <= value[g] + VAL_ONE;
              coil[g] <= geq;
            end
            default: begin
              coil[g] <= 1'b0;
            end
          endcase
        end
      end

      if (KINDS[g] == PTC_UP_COUNT) begin : g_chk_cnt
        chk_count_saturate: assert property (@(posedge mclk) disable iff (!rst_n || sync_clr)
          !sync_clr && value[g] == VAL_MAX |=> value[g] == VAL_MAX)
          else $error("counter left saturation");
        chk_count_step: assert property (@(posedge mclk) disable iff (!rst_n || sync_clr)
          !sync_clr && rise && value[g] < VAL_MAX |=> value[g] == $past(value[g]) + VAL_ONE)
          else $error("counter missed an edge");
        chk_count_coil: assert property (@(posedge mclk) disable iff (!rst_n || sync_clr)
          !sync_clr |=> coil[g] == ($past(value[g]) >= $past(preset[g])))
          else $error("counter coil wrong");
      end
      if (KINDS[g] == PTC_ON_DELAY) begin : g_chk_on
        chk_on_clear: assert property (@(posedge mclk) disable iff (!rst_n || sync_clr)
          !enable[g] |=> value[g] == VAL_ZERO && !coil[g])
          else $error("on-delay not cleared");
        chk_on_tick: assert property (@(posedge mclk) disable iff (!rst_n || sync_clr)
          !sync_clr && enable[g] && first_done[g] && tick && value[g] < VAL_MAX
          |=> value[g] == $past(value[g]) + VAL_ONE)
          else $error("on-delay missed a tick");
      end
      if (KINDS[g] == PTC_RETENTIVE) begin : g_chk_ret
        chk_ret_hold: assert property (@(posedge mclk) disable iff (!rst_n || sync_clr)
          !sync_clr && !enable[g] |=> $stable(value[g]) && $stable(coil[g]))
          else $error("retentive value moved");
      end
      if (KINDS[g] == PTC_OFF_DELAY) begin : g_chk_off
        chk_off_enabled: assert property (@(posedge mclk) disable iff (!rst_n || sync_clr)
          !sync_clr && enable[g] |=> coil[g] && value[g] == VAL_ZERO)
          else $error("off-delay not held on");
        chk_off_idle: assert property (@(posedge mclk) disable iff (!rst_n || sync_clr)
          !sync_clr && !enable[g] && !fall && !active[g] |=> !active[g] && $stable(value[g]))
          else $error("off-delay started without edge");
      end
      if (KINDS[g] == PTC_MONOSTABLE) begin : g_chk_mono
        sequence s_mono_start;
          !sync_clr && !active[g] && rise;
        endsequence
        chk_mono_start: assert property (@(posedge mclk) disable iff (!rst_n || sync_clr)
          s_mono_start |=> active[g] && coil[g])
          else $error("monostable did not start");
        chk_mono_end: assert property (@(posedge mclk) disable iff (!rst_n || sync_clr)
          active[g] && geq |=> !active[g] && !coil[g] && value[g] == VAL_ZERO)
          else $error("monostable did not end");
      end
    end
  endgenerate
endmodule // ptc_timer_counter
`default_nettype wire

// File: dv/ptc_scan_model.sv
// scan-side model: owns each element's power flow and preset
// assumes the bench calls its tasks from one thread only
`timescale 1ns/100ps
`default_nettype none
module ptc_scan_model
  import ptc_pkg::*;
#(
  parameter int N = 5
) (
  // clock
  input  wire logic                      mclk,
  // scan outputs
  output var logic [N-1:0]               enable,
  output var logic [ptc_pkg::VAL_W-1:0]  preset [N]
);
  // idle scan: all power flows off
  initial begin
    enable = '0;
    preset = '{default: 16'h0001};
  end
  // a change lands just after an edge and holds until the next call
  task automatic set_en(input int i, input logic b);
    @(posedge mclk);
    enable[i] <= b;
  endtask
  // the counter sits at index 4, inside the 0..32767 counter range
  task automatic set_pre(input int i, input logic [15:0] p);
    @(posedge mclk);
    preset[i] <= p;
  endtask
endmodule // ptc_scan_model
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench for the timer/counter unit, default five kinds
// assumes the scan model drives power flow; tick divider shortened to 4
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ptc_pkg::*;
  typedef struct {int idx; logic [15:0] v; logic c;} ptc_note_type;
  logic         mclk;
  logic         rstn;
  logic         sync_clr;
  logic         tick;
  logic [4:0]   enable;
  logic [4:0]   coil;
  logic [15:0]  preset [5];
  logic [15:0]  value [5];
  logic [31:0]  seed;
  ptc_note_type notes [$];
  event         go;
  int           err_count = 0;
  int           tests_run = 0;
  ptc_scan_model #(.N(5)) scan (.mclk(mclk), .enable(enable), .preset(preset));
  ptc_timer_counter #(.TICK_DIV(32'h00000004)) dut (.mclk(mclk), .rstn(rstn), .sync_clr(sync_clr),
    .enable(enable), .preset(preset), .value(value), .coil(coil), .tick(tick));
  // free-running clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // note the expectation off the edge so the monitor sees settled outputs
  task automatic expect_st(input int i, input logic [15:0] v, input logic c);
    #1;
    notes.push_back('{i, v, c});
    -> go;
    #1;
  endtask
  // bounded wait for a coil level
  task automatic wait_coil(input int i, input logic c);
    for (int k = 0; k < 200 && coil[i] !== c; k++) begin
      cyc(1);
      #1;
    end
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      scan.set_en(4, 1'b1);
      scan.set_en(4, 1'b0);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // monitor: oldest note against the outputs
  initial begin
    ptc_note_type n;
    forever begin
      @go;
      n = notes.pop_front();
      tests_run++;
      if (value[n.idx] !== n.v || coil[n.idx] !== n.c) begin
        err_count++;
        $display("Error element %0d value/coil expected %h/%b seen %h/%b", n.idx, n.v, n.c, value[n.idx],
                 coil[n.idx]);
      end
    end
  end
  // watchdog: the counter saturation run dominates, about 66k cycles
  initial begin
    cyc(90000);
    err_count++;
    $display("Error watchdog expected done seen running");
    end_of_test();
  end
  // main sequence
  initial begin
    logic [15:0] p;
    int          k;
    seed = 32'h71C7DB7E;
    rstn = 1'b0;
    sync_clr = 1'b0;
    cyc(2);
    rstn <= 1'b1;
    cyc(3);
    for (int i = 0; i < 5; i++) expect_st(i, 16'h0000, 1'b0);
    // tick spacing must match the divider given to the dut
    cyc(1);
    #1;
    for (k = 0; k < 8 && tick !== 1'b1; k++) begin
      cyc(1);
      #1;
    end
    for (k = 1; k < 8; k++) begin
      cyc(1);
      #1;
      if (tick === 1'b1) break;
    end
    tests_run++;
    if (k != 4) begin
      err_count++;
      $display("Error tick period expected 4 seen %0d", k);
    end
    $display("tick test done");
    p = 16'(rnd() % 5) + 16'h0002;
    for (int i = 0; i < 4; i++) scan.set_pre(i, p);
    scan.set_en(0, 1'b1);
    wait_coil(0, 1'b1);
    expect_st(0, p, 1'b1);
    scan.set_en(0, 1'b0);
    cyc(2);
    expect_st(0, 16'h0000, 1'b0);
    scan.set_en(1, 1'b1);
    wait_coil(1, 1'b1);
    scan.set_en(1, 1'b0);
    cyc(12);
    expect_st(1, p, 1'b1);
    $display("on-delay tests done");
    scan.set_en(2, 1'b1);
    cyc(2);
    expect_st(2, 16'h0000, 1'b1);
    scan.set_en(2, 1'b0);
    wait_coil(2, 1'b0);
    expect_st(2, p, 1'b0);
    cyc(20);
    expect_st(2, p, 1'b0);
    scan.set_en(3, 1'b1);
    scan.set_en(3, 1'b0);
    scan.set_en(3, 1'b1);
    wait_coil(3, 1'b0);
    expect_st(3, 16'h0000, 1'b0);
    cyc(20);
    expect_st(3, 16'h0000, 1'b0);
    scan.set_en(3, 1'b0);
    $display("off-delay and monostable tests done");
    scan.set_pre(4, 16'h0004);
    pulse(3);
    cyc(3);
    expect_st(4, 16'h0003, 1'b0);
    pulse(1);
    cyc(3);
    expect_st(4, 16'h0004, 1'b1);
    scan.set_pre(4, 16'h7FFF);
    pulse(32763);
    cyc(3);
    expect_st(4, 16'h7FFF, 1'b1);
    pulse(2);
    cyc(3);
    expect_st(4, 16'h7FFF, 1'b1);
    $display("counter tests done");
    // clear launched on an edge, like every other input
    cyc(1);
    sync_clr <= 1'b1;
    cyc(1);
    sync_clr <= 1'b0;
    cyc(2);
    for (int i = 0; i < 5; i++) expect_st(i, 16'h0000, 1'b0);
    $display("clear test done");
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
